// ==== core/iocr_core.sv ====
// Serial-port register block for sensor outputs and calibration.
// What this block does
// R01: Inertial results are 14-bit two's complement.
// R02: Supply result 14-bit unsigned, 2.418 mV steps.
// R03: Rate weight 0.05 dps, scales with range.
// R04: Temperature 12-bit two's complement, 0.14 C.
// R05: Auxiliary converter 12-bit unsigned, 806 uV.
// R06: New-data flag clears on read, sets on sample.
// R07: Alarm flag mirrors any active diagnostic error.
// R08: Low 14 bits of outputs hold data.
// R09: Rate trim bits 12:0, added to output.
// R10: Accel trim bits 11:0, two's complement.
// R11: Hard-iron trim bits 13:0, two's complement.
// R12: Soft-iron scale bits 11:0, unity 0x0800.
// R13: Autonull negates rates into trims, then saves.
// R14: Precision autonull: offline 30 s, trims, save.
// R15: Factory restore zeroes trims, data, then saves.
// R16: Trigger bits self-clear when operation completes.
// R17: Software reset reloads controls from saved copy.
// R18: Reading the command register starts burst.
// R19: Command bits 7,4,3,2,1,0 as listed.
// R20: Misc control bit 7 enables acceleration compensation.
// R21: Host writes sixteen bits as two bytes.
// R22: Frames with top bit set write one byte.
// R23: Register lower byte at address, upper next.
// R24: All new-data flags set together.
`timescale 1ns/1ps
module iocr_core #(
    parameter int FLASH_CYCLES_P = iocr_pkg::FLASH_CYCLES,
    parameter int PRECISION_CYCLES_P = iocr_pkg::PRECISION_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Serial port pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_din,
    output logic spi_dout,
    // Sensor front end
    input wire logic sample_strobe,
    input wire iocr_pkg::iocr_raw_s raw,
    input wire logic [2:0] rate_range,
    input wire logic [15:0] diagnostic_status,
    // Control outputs
    output logic accel_comp_en,
    output logic dac_latch,
    output logic sensor_restart,
    output logic nv_write,
    output logic [15:0] nonvolatile_write_count,
    output logic busy
);
    import iocr_pkg::*;

    iocr_regs_s q;
    iocr_regs_s n;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_idle;
    logic frame_end;
    logic [15:0] frame;
    logic [5:0] addr;
    logic read_hit;
    logic sample_take;

    // ==========================================================
    // Helpers
    function automatic logic [13:0] sat14(logic signed [31:0] v);
        if (v > 32'sh1FFF) begin
            return 14'h1FFF;
        end
        if (v < -32'sh2000) begin
            return 14'h2000;
        end
        return v[13:0];
    endfunction : sat14

    function automatic int rate_shift(logic [2:0] r);
        case (r)
            3'h2: return 1;
            3'h1: return 0;
            default: return 2;
        endcase
    endfunction : rate_shift

    function automatic logic [15:0] trim_mask(int i);
        if (i < TRIM_ACCEL) begin
            return RATE_TRIM_MASK;
        end
        if (i < TRIM_HARD) begin
            return ACCEL_TRIM_MASK;
        end
        if (i < TRIM_SOFT) begin
            return HARD_TRIM_MASK;
        end
        return SOFT_TRIM_MASK;
    endfunction : trim_mask

    // Negated rate in trim units; both share the 0.0125 dps step.
    function automatic logic [15:0] null_trim(logic [15:0] r);
        return 16'(-r) & RATE_TRIM_MASK;
    endfunction : null_trim

    function automatic logic [15:0] sample_word(iocr_regs_s r, int i);
        return {r.new_data, r.alarm, r.smp[i]}; // [R06] [R07] [R08]
    endfunction : sample_word

    function automatic logic [15:0] read_word(iocr_regs_s r,
                                              logic [5:0] a);
        int i;
        i = 0;
        if (a >= ADDR_FIRST_SAMPLE && a <= ADDR_LAST_SAMPLE) begin
            i = int'((a - ADDR_FIRST_SAMPLE) >> 1);
            return sample_word(r, i);
        end
        if (a >= ADDR_FIRST_TRIM && a <= ADDR_LAST_TRIM) begin
            i = int'((a - ADDR_FIRST_TRIM) >> 1);
            return r.trim[i];
        end
        case (a[5:1])
            ADDR_WRITE_COUNT[5:1]: return r.write_count;
            ADDR_MISC[5:1]: return r.misc;
            ADDR_DIAG[5:1]: return diagnostic_status;
            default: return 16'h0000;
        endcase
    endfunction : read_word

    // ==========================================================
    // Pin decode; all three pins are read only after two flops.
    assign sclk_rise = q.sync[2] & ~q.prev[2];
    assign sclk_fall = ~q.sync[2] & q.prev[2];
    assign cs_idle = q.sync[1];
    assign frame = {q.rx[14:0], q.sync[0]};
    assign frame_end = ~cs_idle & sclk_rise & (q.bit_cnt == BIT_LAST);
    assign addr = frame[13:8];
    assign read_hit = frame_end & ~frame[15] & (q.burst == 4'h0) &
        ((addr >= ADDR_FIRST_SAMPLE && addr <= ADDR_LAST_SAMPLE) ||
         addr[5:1] == ADDR_GLOBAL[5:1]);
    // Sampling stops while the precision run holds the sensor offline.
    assign sample_take = sample_strobe & (q.st != ST_COLLECT) &
        ~q.cmd[CMD_SW_RESET];

    // ==========================================================
    // Next state
    always_comb begin
        int sh;
        int k;
        logic signed [31:0] acc;
        sh = rate_shift(rate_range);
        k = 0;
        acc = '0;
        n = q;
        n.meta = {spi_sclk, spi_cs_n, spi_din};
        n.sync = q.meta;
        n.prev = q.sync;
        n.dac_latch = 1'b0;
        n.restart = 1'b0;
        n.nv_write = 1'b0;
        n.alarm = |diagnostic_status; // [R07]

        // Mode 3 shifting: capture on rise, next bit out on fall.
        if (cs_idle) begin
            n.bit_cnt = 4'h0;
            n.burst = 4'h0;
        end else if (sclk_fall && q.bit_cnt != 4'h0) begin
            n.tx = {q.tx[14:0], 1'b0};
        end else if (sclk_rise) begin
            n.bit_cnt = q.bit_cnt + 4'h1;
            n.rx = frame;
        end

        if (sample_take) begin
            n.smp[SMP_SUPPLY] = raw.supply; // [R02]
            for (int i = 0; i < 3; i++) begin
                acc = 32'($signed(raw.rate[i])) +
                    32'($signed(q.trim[i][12:0])); // [R09]
                n.smp[SMP_RATE+i] = sat14(acc >>> sh); // [R01] [R03]
                acc = 32'($signed(raw.accel[i])) +
                    32'($signed(q.trim[TRIM_ACCEL+i][11:0])); // [R10]
                n.smp[SMP_ACCEL+i] = sat14(acc); // [R01]
                acc = 32'($signed(raw.field[i])) +
                    32'($signed(q.trim[TRIM_HARD+i][13:0])); // [R11]
                acc = acc * $signed({20'h0, q.trim[TRIM_SOFT+i][11:0]});
                n.smp[SMP_FIELD+i] = sat14(acc >>> SOFT_SHIFT); // [R12]
            end
            n.smp[SMP_TEMP] = {2'h0, raw.temp}; // [R04]
            n.smp[SMP_AUX] = {2'h0, raw.aux}; // [R05]
            n.last_rate = raw.rate;
        end

        case (q.st)
            ST_IDLE: begin
                if (q.cmd[CMD_SW_RESET]) begin
                    n.trim = q.trim_nv; // [R17]
                    n.misc = q.misc_nv;
                    n.smp = '0;
                    n.restart = 1'b1;
                    n.cmd[CMD_SW_RESET] = 1'b0; // [R16]
                end else if (q.cmd[CMD_RESTORE]) begin
                    n.trim = '0; // [R15]
                    n.smp = '0;
                    n.st = ST_FLASH;
                    n.timer = 32'(FLASH_CYCLES_P - 1);
                    n.busy = 1'b1;
                end else if (q.cmd[CMD_NULL]) begin
                    for (int i = 0; i < 3; i++) begin
                        n.trim[i] = null_trim(q.last_rate[i]); // [R13]
                    end
                    n.smp = '0;
                    n.st = ST_FLASH;
                    n.timer = 32'(FLASH_CYCLES_P - 1);
                    n.busy = 1'b1;
                end else if (q.cmd[CMD_PRECISION]) begin
                    n.st = ST_COLLECT; // [R14]
                    n.timer = 32'(PRECISION_CYCLES_P - 1);
                    n.busy = 1'b1;
                end else if (q.cmd[CMD_FLASH]) begin
                    n.st = ST_FLASH;
                    n.timer = 32'(FLASH_CYCLES_P - 1);
                    n.busy = 1'b1;
                end
                if (q.cmd[CMD_DAC]) begin
                    n.dac_latch = 1'b1;
                    n.cmd[CMD_DAC] = 1'b0; // [R16]
                end
            end
            ST_COLLECT: begin
                if (q.timer == 32'h0) begin
                    for (int i = 0; i < 3; i++) begin
                        n.trim[i] = null_trim(q.last_rate[i]); // [R14]
                    end
                    n.smp = '0;
                    n.st = ST_FLASH;
                    n.timer = 32'(FLASH_CYCLES_P - 1);
                end else begin
                    n.timer = q.timer - 32'h1;
                end
            end
            ST_FLASH: begin
                if (q.timer == 32'h0) begin
                    n.trim_nv = q.trim;
                    n.misc_nv = q.misc;
                    n.write_count = q.write_count + 16'h1;
                    n.nv_write = 1'b1;
                    n.cmd = q.cmd & ~CMD_NV_OPS; // [R16]
                    n.st = ST_IDLE;
                    n.busy = 1'b0;
                end else begin
                    n.timer = q.timer - 32'h1;
                end
            end
            default: begin
                n.st = ST_IDLE;
                n.busy = 1'b0;
            end
        endcase

        // Frame end comes after the state machine so a host write wins over a clear.
        if (frame_end) begin
            n.bit_cnt = 4'h0;
            n.tx = 16'h0000;
            if (q.burst != 4'h0) begin
                if (q.burst < 4'(NUM_SAMPLES)) begin
                    n.tx = sample_word(q, int'(q.burst));
                    n.burst = q.burst + 4'h1;
                end else begin
                    n.burst = 4'h0;
                end
            end else if (frame[15]) begin
                if (addr >= ADDR_FIRST_TRIM && addr <= ADDR_LAST_TRIM)
                begin
                    k = int'((addr - ADDR_FIRST_TRIM) >> 1); // [R23]
                    if (addr[0]) begin
                        n.trim[k][15:8] = frame[7:0]; // [R22] [R21]
                    end else begin
                        n.trim[k][7:0] = frame[7:0]; // [R22]
                    end
                    n.trim[k] = n.trim[k] & trim_mask(k);
                end else if (addr == ADDR_MISC) begin
                    n.misc[7:0] = frame[7:0]; // [R20]
                end else if (addr == ADDR_MISC + 6'h1) begin
                    n.misc[15:8] = frame[7:0];
                end else if (addr == ADDR_GLOBAL) begin
                    n.cmd = n.cmd | (frame[7:0] & CMD_USED); // [R19]
                end
            end else if (addr[5:1] == ADDR_GLOBAL[5:1]) begin
                n.tx = sample_word(q, SMP_SUPPLY); // [R18]
                n.burst = 4'h1;
            end else begin
                n.tx = read_word(q, addr);
            end
        end
        if (q.cmd[CMD_SW_RESET] && q.st == ST_IDLE) begin
            n.new_data = 1'b0;
        end else begin
            // A sample landing with a read keeps the flag set.
            n.new_data = (q.new_data & ~read_hit) | sample_take; // [R24]
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.meta <= PINS_IDLE;
            q.sync <= PINS_IDLE;
            q.prev <= PINS_IDLE;
            q.st <= ST_IDLE;
            q.misc <= MISC_RESET;
            q.misc_nv <= MISC_RESET;
            for (int i = TRIM_SOFT; i < NUM_TRIMS; i++) begin
                q.trim[i] <= SOFT_UNITY; // [R12]
                q.trim_nv[i] <= SOFT_UNITY;
            end
        end else begin
            q <= n;
        end
    end

    assign spi_dout = q.tx[15];
    assign accel_comp_en = q.misc[MISC_ACCEL_COMP]; // [R20]
    assign dac_latch = q.dac_latch;
    assign sensor_restart = q.restart;
    assign nv_write = q.nv_write;
    assign nonvolatile_write_count = q.write_count;
    assign busy = q.busy;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    logic [15:0] status_word;
    assign status_word = sample_word(q, SMP_SUPPLY);

    sequence s_null_start;
        q.st == ST_IDLE && q.cmd[CMD_NULL] && !frame_end &&
            !q.cmd[CMD_SW_RESET] && !q.cmd[CMD_RESTORE];
    endsequence
    sequence s_burst_req;
        frame_end && q.burst == 4'h0 && frame == BURST_READ;
    endsequence

    new_data_set_a: assert property ( // [R06]
        sample_take |=> q.new_data)
        else $error("new data flag not set by sample");
    alarm_flag_a: assert property ( // [R07]
        (|diagnostic_status) |=> q.alarm ##0 status_word[14])
        else $error("alarm flag does not follow status");
    rate_trim_bits_a: assert property ( // [R09]
        (q.trim[0] | q.trim[1] | q.trim[2]) <= RATE_TRIM_MASK)
        else $error("rate trim unused bits set");
    soft_reset_value_a: assert property ( // [R12]
        $rose(resetn) |-> q.trim[TRIM_SOFT] == SOFT_UNITY)
        else $error("soft-iron default wrong");
    null_trim_load_a: assert property ( // [R13]
        s_null_start |=> q.trim[0] == null_trim($past(q.last_rate[0]))
            ##0 q.st == ST_FLASH ##0 q.smp == '0)
        else $error("autonull did not load negated rate");
    restore_zero_a: assert property ( // [R15]
        q.st == ST_IDLE && q.cmd[CMD_RESTORE] && !q.cmd[CMD_SW_RESET]
        && !frame_end |=> q.trim == '0)
        else $error("factory restore left trim");
    flash_done_a: assert property ( // [R16]
        q.st == ST_FLASH && q.timer == 32'h0 && !frame_end
        |=> !q.cmd[CMD_FLASH] && q.nv_write && q.st == ST_IDLE)
        else $error("flash trigger not cleared");
    soft_reload_a: assert property ( // [R17]
        q.st == ST_IDLE && q.cmd[CMD_SW_RESET] && !frame_end
        |=> q.trim == $past(q.trim_nv) ##1 !q.cmd[CMD_SW_RESET])
        else $error("software reset did not reload");
    burst_start_a: assert property ( // [R18]
        s_burst_req |=> q.burst == 4'h1 && q.tx[13:0] == $past(q.smp[0]))
        else $error("burst read not started");
    byte_write_a: assert property ( // [R22]
        frame_end && q.burst == 4'h0 && frame[15] &&
        addr == ADDR_FIRST_TRIM + 6'h1
        |=> q.trim[0][12:8] == $past(frame[4:0]))
        else $error("upper byte write lost");
endmodule : iocr_core

// ==== core/iocr_pkg.sv ====
// Constants and types for the inertial output and calibration registers.
package iocr_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int FLASH_MS = 50;
    localparam int PRECISION_S = 30;
    localparam int FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);
    localparam int PRECISION_CYCLES = PRECISION_S * CLK_HZ;
    // ==========================================================
    // Byte addresses
    localparam logic [5:0] ADDR_WRITE_COUNT = 6'h00;
    localparam logic [5:0] ADDR_FIRST_SAMPLE = 6'h02;
    localparam logic [5:0] ADDR_LAST_SAMPLE = 6'h19;
    localparam logic [5:0] ADDR_FIRST_TRIM = 6'h1A;
    localparam logic [5:0] ADDR_LAST_TRIM = 6'h31;
    localparam logic [5:0] ADDR_MISC = 6'h34;
    localparam logic [5:0] ADDR_DIAG = 6'h3C;
    localparam logic [5:0] ADDR_GLOBAL = 6'h3E;
    localparam logic [15:0] BURST_READ = 16'h3E00;
    // ==========================================================
    // Register slots
    localparam int NUM_SAMPLES = 12;
    localparam int NUM_TRIMS = 12;
    localparam int SMP_SUPPLY = 0;
    localparam int SMP_RATE = 1;
    localparam int SMP_ACCEL = 4;
    localparam int SMP_FIELD = 7;
    localparam int SMP_TEMP = 10;
    localparam int SMP_AUX = 11;
    localparam int TRIM_ACCEL = 3;
    localparam int TRIM_HARD = 6;
    localparam int TRIM_SOFT = 9;
    // ==========================================================
    // Fields and reset values
    localparam logic [15:0] RATE_TRIM_MASK = 16'h1FFF;
    localparam logic [15:0] ACCEL_TRIM_MASK = 16'h0FFF;
    localparam logic [15:0] HARD_TRIM_MASK = 16'h3FFF;
    localparam logic [15:0] SOFT_TRIM_MASK = 16'h0FFF;
    localparam logic [15:0] SOFT_UNITY = 16'h0800;
    localparam logic [15:0] MISC_RESET = 16'h0006;
    localparam int SOFT_SHIFT = 11;
    localparam int MISC_ACCEL_COMP = 7;
    localparam int CMD_SW_RESET = 7;
    localparam int CMD_PRECISION = 4;
    localparam int CMD_FLASH = 3;
    localparam int CMD_DAC = 2;
    localparam int CMD_RESTORE = 1;
    localparam int CMD_NULL = 0;
    localparam logic [7:0] CMD_USED = 8'h9F;
    localparam logic [7:0] CMD_NV_OPS = 8'h1B;
    localparam logic [2:0] PINS_IDLE = 3'h6;
    localparam logic [3:0] BIT_LAST = 4'hF;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FLASH = 2'h1,
        ST_COLLECT = 2'h3
    } iocr_state_e;

    typedef struct packed {
        logic [13:0] supply;
        logic [2:0][15:0] rate;
        logic [2:0][13:0] accel;
        logic [2:0][13:0] field;
        logic [11:0] temp;
        logic [11:0] aux;
    } iocr_raw_s;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic [2:0] prev;
        logic [3:0] bit_cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [3:0] burst;
        iocr_state_e st;
        logic [31:0] timer;
        logic [7:0] cmd;
        logic [15:0] misc;
        logic [15:0] misc_nv;
        logic [NUM_TRIMS-1:0][15:0] trim;
        logic [NUM_TRIMS-1:0][15:0] trim_nv;
        logic [NUM_SAMPLES-1:0][13:0] smp;
        logic [2:0][15:0] last_rate;
        logic new_data;
        logic alarm;
        logic [15:0] write_count;
        logic dac_latch;
        logic restart;
        logic nv_write;
        logic busy;
    } iocr_regs_s;
endpackage : iocr_pkg

// ==== verif/iocr_core_bench.sv ====
// Self-checking bench for the output and calibration register block.
`timescale 1ns/1ps
module iocr_core_bench;
    import iocr_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic spi_sclk, spi_cs_n, spi_din, spi_dout;
    logic sample_strobe = 1'b0;
    iocr_raw_s raw = '0;
    logic [2:0] rate_range = 3'h4;
    logic [15:0] diagnostic_status = 16'h0000;
    logic accel_comp_en, dac_latch, sensor_restart, nv_write, busy;
    logic [15:0] nonvolatile_write_count;
    logic [15:0] r;
    logic [15:0] burst_exp [12];
    int err_total = 0;
    int cmp_count = 0;
    int dac_seen = 0;
    int restart_seen = 0;
    int nv_seen = 0;

    always #10 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (dac_latch === 1'b1) dac_seen++;
        if (sensor_restart === 1'b1) restart_seen++;
        if (nv_write === 1'b1) nv_seen++;
    end

    iocr_core #(.FLASH_CYCLES_P(20), .PRECISION_CYCLES_P(40)) i_iocr_core (
        .sys_clk(sys_clk), .resetn(resetn), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
        .sample_strobe(sample_strobe), .raw(raw), .rate_range(rate_range),
        .diagnostic_status(diagnostic_status),
        .accel_comp_en(accel_comp_en), .dac_latch(dac_latch),
        .sensor_restart(sensor_restart), .nv_write(nv_write),
        .nonvolatile_write_count(nonvolatile_write_count), .busy(busy));

    iocr_host_model i_iocr_host_model (
        .sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_din(spi_din), .spi_dout(spi_dout));

    // ==========================================================
    // Tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr8(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] x;
        i_iocr_host_model.xfer({2'b10, a, d}, x);
    endtask : wr8

    task automatic wr16(input logic [5:0] a, input logic [15:0] d);
        wr8(a + 6'h01, d[15:8]);
        wr8(a, d[7:0]);
    endtask : wr16

    task automatic rd16(input logic [5:0] a, output logic [15:0] d);
        logic [15:0] x;
        i_iocr_host_model.xfer({2'b00, a, 8'h00}, x);
        i_iocr_host_model.xfer(16'h0000, d);
    endtask : rd16

    task automatic rd_check(input logic [5:0] a, input logic [15:0] exp);
        rd16(a, r);
        check(r, exp);
    endtask : rd_check

    task automatic strobe();
        @(negedge sys_clk);
        sample_strobe = 1'b1;
        @(negedge sys_clk);
        sample_strobe = 1'b0;
    endtask : strobe

    // Waits for the operation to finish; a hang counts as a mismatch.
    task automatic cmd(input logic [7:0] c);
        int n;
        n = 0;
        wr8(ADDR_GLOBAL, c);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 200) begin
            err_total++;
            $display("Error at %0t: busy never fell", $time);
        end
    endtask : cmd

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    initial begin
        #1_000_000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        burst_exp = '{16'h0814, 16'h0064, 16'h3FFF, 16'h0000, 16'h3FFF,
            16'h0000, 16'h0000, 16'h0065, 16'h0000, 16'h0000, 16'h0FFF,
            16'h04D9};
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        i_iocr_host_model.select(1'b1);
        rd_check(6'h1A, 16'h0000);
        rd_check(6'h2C, 16'h0800);
        wr16(6'h1A, 16'h1FF6);
        rd_check(6'h1A, 16'h1FF6);
        raw.supply = 14'h0814;
        raw.rate[0] = 16'h019A;
        raw.rate[1] = 16'hFFFC;
        raw.accel[0] = 14'h3FFF;
        raw.field[0] = 14'h0065;
        raw.temp = 12'hFFF;
        raw.aux = 12'h4D9;
        // Each narrower range doubles the trimmed result.
        for (int k = 0; k < 3; k++) begin
            rate_range = 3'h4 >> k;
            strobe();
            rd_check(6'h04, 16'h8000 | (16'h0064 << k));
        end
        rd_check(6'h04, 16'h0190);
        rate_range = 3'h4;
        diagnostic_status = 16'h0001;
        strobe();
        i_iocr_host_model.xfer(BURST_READ, r);
        for (int k = 0; k < 12; k++) begin
            i_iocr_host_model.xfer(16'h0000, r);
            // The request frame clears the new-data flag part way through.
            check({1'b0, r[14:0]}, 16'h4000 | burst_exp[k]);
        end
        i_iocr_host_model.xfer(16'h0000, r);
        check(r, 16'h0000);
        rd_check(ADDR_DIAG, 16'h0001);
        diagnostic_status = 16'h0000;
        i_iocr_host_model.select(1'b0);
        i_iocr_host_model.select(1'b1);
        wr16(6'h20, 16'hFFFF);
        rd_check(6'h20, 16'h0FFF);
        wr16(6'h26, 16'hFFFF);
        rd_check(6'h26, 16'h3FFF);
        wr16(6'h2C, 16'hFFFF);
        rd_check(6'h2C, 16'h0FFF);
        wr8(ADDR_MISC, 8'h86);
        check({15'h0, accel_comp_en}, 16'h0001);
        rd_check(ADDR_MISC, 16'h0086);
        cmd(8'h01);
        rd_check(6'h1A, 16'h1E66);
        rd16(6'h04, r);
        check({2'b00, r[13:0]}, 16'h0000);
        check(nonvolatile_write_count, 16'h0001);
        cmd(8'h02);
        rd_check(6'h1A, 16'h0000);
        rd_check(6'h20, 16'h0000);
        check(nonvolatile_write_count, 16'h0002);
        cmd(8'h08);
        check(nonvolatile_write_count, 16'h0003);
        wr8(6'h1A, 8'h55);
        cmd(8'h80);
        repeat (10) @(negedge sys_clk);
        rd_check(6'h1A, 16'h0000);
        rd_check(ADDR_MISC, 16'h0086);
        check(16'(restart_seen), 16'h0001);
        cmd(8'h04);
        check(16'(dac_seen), 16'h0001);
        check(nonvolatile_write_count, 16'h0003);
        raw.rate[0] = 16'h0008;
        strobe();
        cmd(8'h10);
        rd_check(6'h1A, 16'h1FF8);
        check(nonvolatile_write_count, 16'h0004);
        check(16'(nv_seen), 16'h0004);
        rd_check(ADDR_WRITE_COUNT, 16'h0004);
        conclude();
    end
endmodule : iocr_core_bench

// ==== verif/iocr_host_model.sv ====
// Host processor model: serial master in mode 3 on the register port.
`timescale 1ns/1ps
module iocr_host_model (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_din,
    input wire logic spi_dout
);
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_din = 1'b1;
    end

    // ==========================================================
    // Bus cycles
    // Half a serial period is four system cycles, giving 80 ns.
    task automatic half();
        repeat (4) @(negedge sys_clk);
    endtask : half

    task automatic select(input logic on);
        @(negedge sys_clk);
        spi_cs_n = ~on;
        half();
    endtask : select

    // The clock stands high between frames and din shows the inverse
    // of its last bit, so a stale level never reads as valid data.
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--) begin
            spi_sclk = 1'b0;
            spi_din = tx[i];
            half();
            spi_sclk = 1'b1;
            rx[i] = spi_dout;
            half();
        end
        spi_din = ~spi_din;
        repeat (8) @(negedge sys_clk);
    endtask : xfer
endmodule : iocr_host_model
